//--- rtl/eccsc_codec.sv
// secded check bit generator and read-side corrector
`timescale 1ns/10ps
`include "eccsc_consts.svh"
module eccsc_codec (
  input  wire logic [`ECCSC_DATA_W-1:0] wdata_i,
  output logic      [`ECCSC_CHK_W-1:0]  wchk_o,
  input  wire logic [`ECCSC_DATA_W-1:0] rdata_i,
  input  wire logic [`ECCSC_CHK_W-1:0]  rchk_i,
  output logic      [`ECCSC_DATA_W-1:0] cdata_o,
  output logic                          sbe_o,
  output logic                          mbe_o
);
  // data bits sit at the non power-of-two positions 3,5,6,7,9..
  function automatic logic [`ECCSC_CHK_W-1:0] ecc_gen(input logic [`ECCSC_DATA_W-1:0] d);
    logic [`ECCSC_CHK_W-1:0] c;
    int                      k;
    c = '0;
    k = 0;
    for (int p = 1; p < 128; p++) begin
      if (((p & (p - 1)) != 0) && (k < `ECCSC_DATA_W)) begin
        if (d[k]) begin
          c[6:0] = c[6:0] ^ 7'(p);
        end
        k++;
      end
    end
    c[7] = (^d) ^ (^c[6:0]);
    return c;
  endfunction

  logic [`ECCSC_CHK_W-1:0] syn;
  logic [`ECCSC_CHK_W-1:0] gen_chk;

  always_comb begin
    wchk_o = ecc_gen(wdata_i);
  end

  always_comb begin
    int k;
    k       = 0;
    gen_chk = ecc_gen(rdata_i);
    // overall parity over all 72 received bits, not over recomputed checks
    syn     = {(^rdata_i) ^ (^rchk_i), gen_chk[6:0] ^ rchk_i[6:0]};
    cdata_o = rdata_i;
    for (int p = 1; p < 128; p++) begin
      if (((p & (p - 1)) != 0) && (k < `ECCSC_DATA_W)) begin
        if (syn[7] && (syn[6:0] == 7'(p))) begin
          cdata_o[k] = ~rdata_i[k];
        end
        k++;
      end
    end
    // odd overall parity means one flip; even with a syndrome means two
    sbe_o = syn[7];
    mbe_o = !syn[7] && (syn[6:0] != 7'h00);
  end
endmodule

//--- rtl/eccsc_consts.svh
// constants for the memory ecc error and scrub block
`ifndef ECCSC_CONSTS_SVH
`define ECCSC_CONSTS_SVH

`define ECCSC_DATA_W      64
`define ECCSC_CHK_W       8
`define ECCSC_ROW_W       2
`define ECCSC_ROW_WORD_W  22

`define ECCSC_OFS_CTRL    8'h00
`define ECCSC_OFS_STATUS  8'h04
`define ECCSC_OFS_MASK    8'h08
`define ECCSC_OFS_ERR_ROW 8'h0c

`define ECCSC_CTRL_ECC_EN 0
`define ECCSC_CTRL_INIT   1
`define ECCSC_ST_SBE      0
`define ECCSC_ST_MBE      1

`define ECCSC_CTRL_RST    2'h1
`define ECCSC_MASK_RST    2'h0

`endif

//--- rtl/eccsc_pkg.sv
// types shared by the memory ecc error and scrub block
package eccsc_pkg;
  typedef enum logic [2:0] {
    ECCSC_IDLE,
    ECCSC_RD_WAIT,
    ECCSC_SC_RD,
    ECCSC_SC_RWAIT,
    ECCSC_SC_WR
  } eccsc_state_t;
endpackage

//--- rtl/eccsc_top.sv
// ecc error path: correction, row scrub, error reporting, ahb-lite registers
`timescale 1ns/10ps
`include "eccsc_consts.svh"
module eccsc_top
  import eccsc_pkg::*;
#(
  parameter int ROW_WORD_W = `ECCSC_ROW_WORD_W
) (
  input  wire logic                                SYS_CLK_I,
  input  wire logic                                NRST_I,
  // ahb-lite slave
  input  wire logic                                HSEL_I,
  input  wire logic [31:0]                         HADDR_I,
  input  wire logic [1:0]                          HTRANS_I,
  input  wire logic                                HWRITE_I,
  input  wire logic [2:0]                          HSIZE_I,
  input  wire logic [31:0]                         HWDATA_I,
  input  wire logic                                HREADY_I,
  output logic                                     HREADYOUT_O,
  output logic      [31:0]                         HRDATA_O,
  output logic                                     HRESP_O,
  // requester side
  input  wire logic                                REQ_VALID_I,
  output logic                                     REQ_READY_O,
  input  wire logic                                REQ_WRITE_I,
  input  wire logic [`ECCSC_ROW_W+ROW_WORD_W-1:0]  REQ_ADDR_I,
  input  wire logic [`ECCSC_DATA_W-1:0]            REQ_WDATA_I,
  output logic                                     RSP_VALID_O,
  output logic      [`ECCSC_DATA_W-1:0]            RSP_RDATA_O,
  // dimm side
  output logic                                     MEM_REQ_O,
  output logic                                     MEM_WE_O,
  output logic      [`ECCSC_ROW_W+ROW_WORD_W-1:0]  MEM_ADDR_O,
  output logic      [`ECCSC_DATA_W-1:0]            MEM_WDATA_O,
  output logic      [`ECCSC_CHK_W-1:0]             MEM_WCHK_O,
  input  wire logic                                MEM_RVALID_I,
  input  wire logic [`ECCSC_DATA_W-1:0]            MEM_RDATA_I,
  input  wire logic [`ECCSC_CHK_W-1:0]             MEM_RCHK_I,
  // error signalling
  output logic                                     SERR_O,
  output logic                                     IRQ_O
);
  localparam int AW = `ECCSC_ROW_W + ROW_WORD_W;

  eccsc_state_t                 state_q;
  logic [AW-1:0]                addr_q;
  logic [ROW_WORD_W-1:0]        idx_q;
  logic [`ECCSC_DATA_W-1:0]     scrub_data_q;
  logic [1:0]                   ctrl_q;
  logic [1:0]                   status_q;
  logic [1:0]                   status_d;
  logic [1:0]                   mask_q;
  logic [`ECCSC_ROW_W-1:0]      err_row_q;
  logic                         ahb_wr_q;
  logic [7:0]                   ahb_ofs_q;
  logic [`ECCSC_DATA_W-1:0]     enc_in;
  logic [`ECCSC_CHK_W-1:0]      enc_chk;
  logic [`ECCSC_DATA_W-1:0]     dec_data;
  logic [`ECCSC_DATA_W-1:0]     out_data;
  logic                         dec_sbe;
  logic                         dec_mbe;
  logic                         ecc_en;
  logic                         det_en;
  logic                         rd_done;
  logic                         ev_sbe;
  logic                         ev_mbe;
  logic                         ahb_sel;
  logic                         last_word;

  eccsc_codec u_codec (
    .wdata_i (enc_in),
    .wchk_o  (enc_chk),
    .rdata_i (MEM_RDATA_I),
    .rchk_i  (MEM_RCHK_I),
    .cdata_o (dec_data),
    .sbe_o   (dec_sbe),
    .mbe_o   (dec_mbe)
  );

  // switching ecc off in ctrl is how firmware handles non-ecc memory
  assign ecc_en    = ctrl_q[`ECCSC_CTRL_ECC_EN];
  assign det_en    = ecc_en && !ctrl_q[`ECCSC_CTRL_INIT];
  assign rd_done   = MEM_RVALID_I && ((state_q == ECCSC_RD_WAIT) ||
                                      (state_q == ECCSC_SC_RWAIT));
  assign ev_sbe    = rd_done && det_en && dec_sbe;
  assign ev_mbe    = rd_done && det_en && dec_mbe;
  assign out_data  = ecc_en ? dec_data : MEM_RDATA_I;
  assign enc_in    = (state_q == ECCSC_SC_WR) ? scrub_data_q : REQ_WDATA_I;
  assign last_word = (idx_q == {ROW_WORD_W{1'b1}});
  assign REQ_READY_O = (state_q == ECCSC_IDLE);

  // sequencer: plain reads and writes, then a whole-row scrub after a fix while init is clear
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      state_q      <= ECCSC_IDLE;
      addr_q       <= '0;
      idx_q        <= '0;
      scrub_data_q <= '0;
    end else begin
      case (state_q)
        ECCSC_IDLE: begin
          if (REQ_VALID_I && !REQ_WRITE_I) begin
            addr_q  <= REQ_ADDR_I;
            state_q <= ECCSC_RD_WAIT;
          end
        end
        ECCSC_RD_WAIT: begin
          if (MEM_RVALID_I) begin
            idx_q   <= '0;
            // scrub needs no enable of its own beyond ecc being on and init being clear
            state_q <= (ev_sbe && !dec_mbe) ? ECCSC_SC_RD : ECCSC_IDLE;
          end
        end
        ECCSC_SC_RD: begin
          state_q <= ECCSC_SC_RWAIT;
        end
        ECCSC_SC_RWAIT: begin
          if (MEM_RVALID_I) begin
            scrub_data_q <= out_data;
            state_q      <= ECCSC_SC_WR;
          end
        end
        ECCSC_SC_WR: begin
          idx_q   <= idx_q + 1'b1;
          state_q <= last_word ? ECCSC_IDLE : ECCSC_SC_RD;
        end
        default: begin
          state_q <= ECCSC_IDLE;
        end
      endcase
    end
  end

  // dimm command port, registered; check bits always generated so zero-fill
  // leaves valid codes behind it
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      MEM_REQ_O   <= 1'b0;
      MEM_WE_O    <= 1'b0;
      MEM_ADDR_O  <= '0;
      MEM_WDATA_O <= '0;
      MEM_WCHK_O  <= '0;
    end else begin
      MEM_REQ_O <= 1'b0;
      MEM_WE_O  <= 1'b0;
      if (state_q == ECCSC_IDLE && REQ_VALID_I) begin
        MEM_REQ_O   <= 1'b1;
        MEM_WE_O    <= REQ_WRITE_I;
        MEM_ADDR_O  <= REQ_ADDR_I;
        MEM_WDATA_O <= enc_in;
        MEM_WCHK_O  <= enc_chk;
      end else if (state_q == ECCSC_SC_RD) begin
        MEM_REQ_O  <= 1'b1;
        MEM_ADDR_O <= {addr_q[AW-1 -: `ECCSC_ROW_W], idx_q};
      end else if (state_q == ECCSC_SC_WR) begin
        MEM_REQ_O   <= 1'b1;
        MEM_WE_O    <= 1'b1;
        MEM_ADDR_O  <= {addr_q[AW-1 -: `ECCSC_ROW_W], idx_q};
        MEM_WDATA_O <= enc_in;
        MEM_WCHK_O  <= enc_chk;
      end
    end
  end

  // answer to the requester, corrected word while ecc is on, raw word with it off
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      RSP_VALID_O <= 1'b0;
      RSP_RDATA_O <= '0;
    end else begin
      RSP_VALID_O <= (state_q == ECCSC_RD_WAIT) && MEM_RVALID_I;
      if ((state_q == ECCSC_RD_WAIT) && MEM_RVALID_I) begin
        RSP_RDATA_O <= out_data;
      end
    end
  end

  // error signalling; only the row is known, never the word
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      SERR_O    <= 1'b0;
      err_row_q <= '0;
    end else begin
      SERR_O <= ev_mbe;
      if (ev_sbe || ev_mbe) begin
        err_row_q <= addr_q[AW-1 -: `ECCSC_ROW_W];
      end
    end
  end

  // ahb-lite slave, zero wait states
  assign ahb_sel     = HSEL_I && HTRANS_I[1] && HREADY_I;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;

  // set wins over a write-one clear landing in the same cycle
  always_comb begin
    status_d = status_q;
    if (ahb_wr_q && ahb_ofs_q == `ECCSC_OFS_STATUS) begin
      status_d = status_d & ~HWDATA_I[1:0];
    end
    status_d[`ECCSC_ST_SBE] = status_d[`ECCSC_ST_SBE] | ev_sbe;
    status_d[`ECCSC_ST_MBE] = status_d[`ECCSC_ST_MBE] | ev_mbe;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      ahb_wr_q  <= 1'b0;
      ahb_ofs_q <= '0;
      HRDATA_O  <= '0;
    end else begin
      ahb_wr_q <= ahb_sel && HWRITE_I;
      if (ahb_sel) begin
        ahb_ofs_q <= HADDR_I[7:0];
        case (HADDR_I[7:0])
          `ECCSC_OFS_CTRL:    HRDATA_O <= {30'h0, ctrl_q};
          `ECCSC_OFS_STATUS:  HRDATA_O <= {30'h0, status_q};
          `ECCSC_OFS_MASK:    HRDATA_O <= {30'h0, mask_q};
          `ECCSC_OFS_ERR_ROW: HRDATA_O <= {30'h0, err_row_q};
          default:            HRDATA_O <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      ctrl_q   <= `ECCSC_CTRL_RST;
      mask_q   <= `ECCSC_MASK_RST;
      status_q <= '0;
      IRQ_O    <= 1'b0;
    end else begin
      status_q <= status_d;
      IRQ_O    <= |(status_d & mask_q);
      if (ahb_wr_q && ahb_ofs_q == `ECCSC_OFS_CTRL) begin
        ctrl_q <= HWDATA_I[1:0];
      end
      if (ahb_wr_q && ahb_ofs_q == `ECCSC_OFS_MASK) begin
        mask_q <= HWDATA_I[1:0];
      end
    end
  end

  // checks
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);

  sequence s_fix_seen;
    (state_q == ECCSC_RD_WAIT) && ev_sbe && !dec_mbe;
  endsequence
  sequence s_scrub_readback;
    (state_q == ECCSC_SC_RWAIT) && MEM_RVALID_I;
  endsequence

  a_rsp_corrected: assert property ((state_q == ECCSC_RD_WAIT) && MEM_RVALID_I
    |=> RSP_VALID_O && RSP_RDATA_O == $past(out_data))
    else $error("read answer missing or not corrected");
  a_mbe_status: assert property (ev_mbe |=> status_q[`ECCSC_ST_MBE])
    else $error("uncorrectable error not flagged");
  a_scrub_start: assert property (s_fix_seen ##1 1'b1
    |-> state_q == ECCSC_SC_RD && idx_q == '0 ##1 MEM_REQ_O && !MEM_WE_O)
    else $error("row scrub did not start at word zero");
  a_scrub_wb: assert property (s_scrub_readback ##1 1'b1
    |=> MEM_REQ_O && MEM_WE_O && MEM_WDATA_O == $past(out_data, 2))
    else $error("scrub write-back wrong");
  a_err_row: assert property ((ev_sbe || ev_mbe)
    |=> err_row_q == $past(addr_q[AW-1 -: `ECCSC_ROW_W]))
    else $error("error row not captured");
  a_scrub_auto: assert property ((state_q == ECCSC_RD_WAIT) && MEM_RVALID_I &&
    det_en && dec_sbe |=> state_q == ECCSC_SC_RD)
    else $error("scrub not entered with ecc on");
  a_init_quiet: assert property (rd_done && ctrl_q[`ECCSC_CTRL_INIT]
    |=> !SERR_O && state_q != ECCSC_SC_RD)
    else $error("error raised during zero-fill");
  a_serr_mbe: assert property (ev_mbe |=> SERR_O ##1 !SERR_O || $past(ev_mbe))
    else $error("system error line not pulsed");
  a_sbe_irq: assert property (ev_sbe && mask_q[`ECCSC_ST_SBE] |=> IRQ_O)
    else $error("interrupt missing on corrected error");
endmodule

//--- tb/eccsc_mem_model.sv
// dimm model: data plus check bits, alternating read latency, fault injection
`timescale 1ns/10ps
module eccsc_mem_model #(
  parameter int AW = 5
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          req_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [63:0]   wdata_i,
  input  wire logic [7:0]    wchk_i,
  input  wire logic          flip_i,
  input  wire logic [AW-1:0] flip_addr_i,
  input  wire logic [71:0]   flip_mask_i,
  output logic               rvalid_o,
  output logic [63:0]        rdata_o,
  output logic [7:0]         rchk_o
);
  logic [71:0]   mem_q [2**AW];
  logic          pend_q;
  logic          slow_q;
  logic [1:0]    wait_q;
  logic [AW-1:0] a_q;
  always_ff @(posedge clk_i) begin
    if (flip_i)
      mem_q[flip_addr_i] <= mem_q[flip_addr_i] ^ flip_mask_i;
    if (req_i && we_i)
      mem_q[addr_i] <= {wchk_i, wdata_i};
  end
  always_ff @(posedge clk_i) begin
    rvalid_o <= 1'b0;
    // released lines toggle so stale data never looks valid
    {rchk_o, rdata_o} <= ~{rchk_o, rdata_o};
    if (!rst_n_i) begin
      pend_q <= 1'b0;
      slow_q <= 1'b0;
    end else if (req_i && !we_i) begin
      pend_q <= 1'b1;
      a_q    <= addr_i;
      wait_q <= slow_q ? 2'h3 : 2'h0;
      slow_q <= ~slow_q;
    end else if (pend_q && wait_q == 2'h0) begin
      rvalid_o          <= 1'b1;
      {rchk_o, rdata_o} <= mem_q[a_q];
      pend_q            <= 1'b0;
    end else if (pend_q) begin
      wait_q <= wait_q - 2'h1;
    end
  end
endmodule

//--- tb/eccsc_top_tb.sv
// self-checking bench for the ecc error and scrub block
`timescale 1ns/10ps
`include "eccsc_consts.svh"
module eccsc_top_tb;
  localparam int          AW = `ECCSC_ROW_W + 3;
  localparam logic [31:0] CT = 32'(`ECCSC_OFS_CTRL);
  localparam logic [31:0] ST = 32'(`ECCSC_OFS_STATUS);
  localparam logic [31:0] MK = 32'(`ECCSC_OFS_MASK);
  localparam logic [31:0] ER = 32'(`ECCSC_OFS_ERR_ROW);
  localparam logic [63:0] D1 = 64'h00c0_ffee_1234_5678;
  localparam logic [63:0] D2 = 64'ha5a5_5a5a_0f0f_f0f0;
  // fewest good words that let start-up go on, floor scaled to the model
  localparam int          MIN_GOOD = 2;
  logic          clk = 1'b0;
  logic          nrst = 1'b0;
  logic          hsel = 1'b0;
  logic          hwrite = 1'b0;
  logic [1:0]    htrans = 2'h0;
  logic [31:0]   haddr = '0;
  logic [31:0]   hwdata = '0;
  logic [31:0]   hrdata;
  logic          hready, hresp, irq, serr, rr, rsv, mreq, mwe, mrv;
  logic          rv = 1'b0;
  logic          rwr = 1'b0;
  logic          flip = 1'b0;
  logic [AW-1:0] ra = '0;
  logic [AW-1:0] fa = '0;
  logic [AW-1:0] maddr;
  logic [71:0]   fm = '0;
  logic [63:0]   rwd = '0;
  logic [63:0]   rsd, mwd, mrd, rd;
  logic [7:0]    mwc, mrc;
  int            miscompares = 0;
  int            cmp_count = 0;
  int            serr_n = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (serr === 1'b1) serr_n++;
  eccsc_top #(.ROW_WORD_W(3)) dut (
    .SYS_CLK_I(clk), .NRST_I(nrst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HREADYOUT_O(hready), .HRDATA_O(hrdata), .HRESP_O(hresp),
    .REQ_VALID_I(rv), .REQ_READY_O(rr), .REQ_WRITE_I(rwr), .REQ_ADDR_I(ra),
    .REQ_WDATA_I(rwd), .RSP_VALID_O(rsv), .RSP_RDATA_O(rsd),
    .MEM_REQ_O(mreq), .MEM_WE_O(mwe), .MEM_ADDR_O(maddr), .MEM_WDATA_O(mwd),
    .MEM_WCHK_O(mwc), .MEM_RVALID_I(mrv), .MEM_RDATA_I(mrd), .MEM_RCHK_I(mrc),
    .SERR_O(serr), .IRQ_O(irq));
  eccsc_mem_model #(.AW(AW)) mem (
    .clk_i(clk), .rst_n_i(nrst), .req_i(mreq), .we_i(mwe), .addr_i(maddr),
    .wdata_i(mwd), .wchk_i(mwc), .flip_i(flip), .flip_addr_i(fa),
    .flip_mask_i(fm), .rvalid_o(mrv), .rdata_o(mrd), .rchk_o(mrc));
  task automatic end_sim;
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_hi(ref logic s);
    int n;
    for (n = 0; n < 400; n++) begin
      @(posedge clk);
      if (s === 1'b1) break;
    end
    if (n == 400) begin
      miscompares++;
      $display("FAIL %0t handshake timeout", $time);
      end_sim();
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    wait_hi(hready);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_hi(hready);
    q = hrdata;
  endtask
  task automatic wreg(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
    @(posedge clk);
  endtask
  task automatic rreg(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk({32'h0, q}, {32'h0, e});
  endtask
  task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [63:0] d);
    @(posedge clk);
    rv  <= 1'b1;
    rwr <= w;
    ra  <= a;
    rwd <= d;
    wait_hi(rr);
    rv <= 1'b0;
    if (!w) begin
      wait_hi(rsv);
      rd = rsd;
    end
  endtask
  task automatic corrupt(input logic [AW-1:0] a, input logic [71:0] m);
    @(posedge clk);
    flip <= 1'b1;
    fa   <= a;
    fm   <= m;
    @(posedge clk);
    flip <= 1'b0;
  endtask
  task automatic t_reset;
    rreg(CT, 32'h1);
    rreg(ST, 32'h0);
    rreg(MK, 32'h0);
    rreg(32'h10, 32'h0);
    chk({63'h0, irq}, 64'h0);
  endtask
  task automatic t_init;
    int i;
    int usable;
    wreg(CT, 32'h3);
    for (i = 0; i < 2**AW; i++)
      xfer(1'b1, AW'(i), 64'h0);
    corrupt(5'h03, 72'h3);
    // memory test walks up from zero and cuts the bank at the first bad word
    usable = 2**AW;
    for (i = 0; i < 2**AW && usable == 2**AW; i++) begin
      xfer(1'b0, AW'(i), 64'h0);
      if (rd !== 64'h0) usable = i;
    end
    chk(64'(usable), 64'h3);
    chk(64'(usable >= MIN_GOOD), 64'h1);
    @(posedge clk);
    rreg(ST, 32'h0);
    chk(64'(serr_n), 64'h0);
    xfer(1'b1, 5'h03, 64'h0);
    wreg(CT, 32'h1);
  endtask
  task automatic t_sbe;
    wreg(MK, 32'h3);
    xfer(1'b1, 5'h15, D1);
    corrupt(5'h15, 72'h1 << 9);
    xfer(1'b0, 5'h15, 64'h0);
    chk(rd, D1);
    chk({63'h0, irq}, 64'h1);
    rreg(ST, 32'h1);
    rreg(ER, 32'h2);
    // scrub holds the requester off until the whole row is rewritten
    wait_hi(rr);
    chk(mem.mem_q[5'h15][63:0], D1);
    wreg(ST, 32'h1);
    chk({63'h0, irq}, 64'h0);
    xfer(1'b0, 5'h15, 64'h0);
    @(posedge clk);
    rreg(ST, 32'h0);
    chk(64'(serr_n), 64'h0);
  endtask
  task automatic t_mbe;
    wreg(MK, 32'h1);
    xfer(1'b1, 5'h0a, D2);
    corrupt(5'h0a, 72'h3 << 20);
    xfer(1'b0, 5'h0a, 64'h0);
    @(posedge clk);
    chk(64'(serr_n), 64'h1);
    rreg(ST, 32'h2);
    rreg(ER, 32'h1);
    chk({63'h0, irq}, 64'h0);
    wreg(MK, 32'h3);
    // irq is built from the mask before the write, so unmasking shows an edge later
    @(posedge clk);
    chk({63'h0, irq}, 64'h1);
    wreg(ST, 32'h2);
    rreg(ST, 32'h0);
  endtask
  task automatic t_off;
    wreg(CT, 32'h0);
    xfer(1'b0, 5'h0a, 64'h0);
    chk(rd, D2 ^ (64'h3 << 20));
    @(posedge clk);
    rreg(ST, 32'h0);
    chk(64'(serr_n), 64'h1);
    wreg(CT, 32'h1);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_init();
    t_sbe();
    t_mbe();
    t_off();
    end_sim();
  end
endmodule
